// ---- core/acc_pkg.sv ----
// Shared constants for the converter control block
package acc_pkg;
  // Register bus geometry
  localparam int           ADDR_W      = 8;                 // Register address width
  localparam int           DATA_W      = 8;                 // Register data width
  // Register offsets
  localparam logic [7:0]   OFF_CTRL    = 8'h0E;             // converter_control_reg
  localparam logic [7:0]   OFF_RESULT  = 8'h0F;             // conversion_result_reg
  localparam logic [7:0]   OFF_IRQSTAT = 8'h10;             // Sticky event status
  localparam logic [7:0]   OFF_IRQMASK = 8'h11;             // Event mask
  // Control register fields
  localparam int           BIT_DONE    = 7;                 // conversion_done_flag
  localparam int           BIT_START   = 6;                 // conversion_start_bit
  localparam int           BIT_TSEL    = 5;                 // Conversion time select
  localparam int           BIT_AIDIS   = 4;                 // analog_input_disable
  localparam int           CHAN_MSB    = 3;                 // channel_select top bit
  localparam int           CHAN_W      = 4;                 // channel_select width
  localparam logic [3:0]   CHAN_LAST   = 4'hB;              // Highest routed channel
  localparam logic [7:0]   CTRL_RESET  = 8'h00;             // Control reset value
  // Event status bits
  localparam int           IRQ_W       = 2;                 // Number of events
  localparam int           IRQ_DONE    = 0;                 // Conversion finished
  localparam int           IRQ_ABORT   = 1;                 // Conversion aborted
  localparam logic [1:0]   IRQ_RESET   = 2'h0;              // Status and mask reset
  // Timing, in periods of fc; core_clk is fc
  localparam int           CLK_PER_FC  = 1;                 // core_clk cycles per fc period
  localparam int           CONV_SHORT_FC = 184;             // Short conversion time
  localparam int           CONV_LONG_FC  = 736;             // Long conversion time
  localparam int           MCYC_FC     = 4;                 // fc periods per machine cycle
  localparam int           SAMPLE_MC   = 4;                 // Charge time in machine cycles
  localparam int           CNT_W       = 10;                // Conversion counter width
  localparam logic [9:0]   SHORT_CYC   = 10'(CONV_SHORT_FC * CLK_PER_FC);
  localparam logic [9:0]   LONG_CYC    = 10'(CONV_LONG_FC * CLK_PER_FC);
  localparam logic [9:0]   SAMPLE_CYC  = 10'(SAMPLE_MC * MCYC_FC * CLK_PER_FC);
  localparam logic [9:0]   STEP_SHORT  = 10'h010;           // Cycles per trial bit, short
  localparam logic [9:0]   STEP_LONG   = 10'h040;           // Cycles per trial bit, long
endpackage : acc_pkg

// ---- core/acc_sar_if.sv ----
// Link between the conversion sequencer and the approximation register
`timescale 1ns/1ps
`default_nettype none
interface acc_sar_if #(parameter int RES_W = 8);
  logic             clear;    // Start a fresh approximation
  logic             step;     // Resolve the current trial bit
  logic             compBit;  // Synchronised comparator verdict
  logic [RES_W-1:0] code;     // Trial code toward the DAC
  logic             finished; // All bits resolved
  modport ctl (output clear, output step, output compBit, input code, input finished);
  modport sar (input clear, input step, input compBit, output code, output finished);
endinterface : acc_sar_if
`default_nettype wire

// ---- core/acc_sync3.sv ----
// Three-stage synchroniser that accepts a change once the last two agree
`timescale 1ns/1ps
`default_nettype none
module acc_sync3 (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic asyncIn,
  output var  logic syncOut
);
  logic s1_r; // First stage, read only by the second
  logic s2_r; // Second stage
  logic s3_r; // Third stage

  // Shift chain and agreement filter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      s1_r <= asyncIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Accept only a level seen twice in a row
      if (s2_r == s3_r) begin
        syncOut <= s3_r;
      end
    end
  end
endmodule : acc_sync3
`default_nettype wire

// ---- core/acc_sar.sv ----
// Successive approximation register, one trial bit per step
`timescale 1ns/1ps
`default_nettype none
module acc_sar #(
  parameter int RES_W = 8
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  acc_sar_if.sar    sarIf
);
  logic [$clog2(RES_W)-1:0] bitIdx_r; // Bit under trial

  // Trial, keep or drop, then try the next lower bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sarIf.code     <= '0;
      sarIf.finished <= 1'b0;
      bitIdx_r       <= '0;
    end else if (clkEn) begin
      if (sarIf.clear) begin
        // Begin with only the top bit set
        sarIf.code     <= {1'b1, {(RES_W-1){1'b0}}};
        sarIf.finished <= 1'b0;
        bitIdx_r       <= ($clog2(RES_W))'(RES_W - 1);
      end else if (sarIf.step && !sarIf.finished) begin
        // Input below trial drops the bit
        sarIf.code[bitIdx_r] <= sarIf.compBit;
        if (bitIdx_r == '0) begin
          sarIf.finished <= 1'b1;
        end else begin
          sarIf.code[bitIdx_r - 1'b1] <= 1'b1;
          bitIdx_r                    <= bitIdx_r - 1'b1;
        end
      end
    end
  end
endmodule : acc_sar
`default_nettype wire

// ---- core/acc_conv_ctrl.sv ----
// Converter control, status, result and event logic
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Control bits: done, start, time, disable, channel
// - Codes 0 to 11 route that channel
// - Writing start one begins a conversion
// - Conversion lasts 184 or 736 fc
// - Start during conversion restarts from beginning
// - Input sampled four machine cycles after start
// - Done set at end, read-only, else zero
// - Reading result clears done flag
// - Stop or slow mode clears control register
// - Stop mode aborts a running conversion
// - Stop after completion keeps the result
// - Control register resets to all zeros
module acc_conv_ctrl #(
  parameter int RES_W = 8 // Result width, at most one data byte
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clkEn,
  input  wire logic [acc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [acc_pkg::DATA_W-1:0] regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output var  logic [acc_pkg::DATA_W-1:0] regRdata,
  input  wire logic                      stopMode,
  input  wire logic                      slowMode,
  input  wire logic                      compIn,
  output var  logic [acc_pkg::CHAN_W-1:0] chanSel,
  output var  logic                      analogInEnable,
  output var  logic                      sampleTrack,
  output wire logic [RES_W-1:0]          dacCode,
  output var  logic                      convBusy,
  output var  logic                      irq
);
  logic                      tsel_r;     // Long conversion time when set
  logic                      aiDis_r;    // Analog input disabled when set
  logic [acc_pkg::CHAN_W-1:0] chan_r;    // Channel select field
  logic                      doneFlag_r; // Conversion done flag
  logic [acc_pkg::CNT_W-1:0] convCnt_r;  // Cycles since start
  logic [acc_pkg::CNT_W-1:0] stepCnt_r;  // Cycles to next trial step
  logic [RES_W-1:0]          result_r;   // Last completed conversion
  logic [acc_pkg::IRQ_W-1:0] irqStat_r;  // Sticky event status
  logic [acc_pkg::IRQ_W-1:0] irqMask_r;  // Event mask
  logic [acc_pkg::IRQ_W-1:0] irqStat_nxt;
  logic [acc_pkg::IRQ_W-1:0] irqMask_nxt;
  logic                      lpActive;   // Stop or slow mode active
  logic                      startPulse; // Start bit written as one
  logic                      convEnd;    // Last cycle of a conversion
  logic                      abortEvt;   // Running conversion cut off
  logic                      resultRd;   // Result register read
  logic [acc_pkg::CNT_W-1:0] totalCyc;   // Selected conversion length
  logic [acc_pkg::CNT_W-1:0] stepLen;    // Selected trial step length
  logic [acc_pkg::DATA_W-1:0] ctrlView;  // Control register as read
  logic                      compSync;   // Synchronised comparator

  acc_sar_if #(.RES_W(RES_W)) sarIf ();

  // Address match, shared by read and write decode
  // One compare, so read and write decode cannot drift apart
  function automatic logic hit(input logic [acc_pkg::ADDR_W-1:0] a,
                               input logic [acc_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Strobes and selections decoded once per cycle
  assign lpActive   = stopMode | slowMode;
  assign startPulse = regWr && hit(regAddr, acc_pkg::OFF_CTRL)
                      && regWdata[acc_pkg::BIT_START] && !lpActive;
  assign resultRd   = regRd && hit(regAddr, acc_pkg::OFF_RESULT);
  assign totalCyc   = tsel_r ? acc_pkg::LONG_CYC : acc_pkg::SHORT_CYC;
  assign stepLen    = tsel_r ? acc_pkg::STEP_LONG : acc_pkg::STEP_SHORT;
  assign convEnd    = convBusy && !startPulse && !lpActive
                      && (convCnt_r == totalCyc - 1'b1);
  assign abortEvt   = convBusy && lpActive;
  assign ctrlView   = {doneFlag_r, convBusy, tsel_r, aiDis_r, chan_r};
  assign dacCode    = sarIf.code;

  // Comparator arrives from the analog core, outside this clock
  // Two agreeing stages keep a late edge away from the trial bits
  acc_sync3 u_compSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .asyncIn  (compIn),
    .syncOut  (compSync)
  );

  // Approximation register
  acc_sar #(.RES_W(RES_W)) u_sar (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .sarIf    (sarIf.sar)
  );

  // Clear at the sample point, step on each trial boundary
  // Steps wait for the hold phase, so a stale timer cannot move the code
  assign sarIf.compBit = compSync;
  assign sarIf.clear   = convBusy && (convCnt_r == acc_pkg::SAMPLE_CYC - 1'b1);
  assign sarIf.step    = convBusy && !sampleTrack && (stepCnt_r == 10'h001);

  // Control register fields
  // Low power beats a write in the same cycle; software reprograms
  // the register once normal mode is back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // All zeros: channel 0, input on, short time
      {tsel_r, aiDis_r, chan_r} <= acc_pkg::CTRL_RESET[acc_pkg::BIT_TSEL:0];
    end else if (clkEn) begin
      if (lpActive) begin
        // Low-power entry wipes the settings
        {tsel_r, aiDis_r, chan_r} <= acc_pkg::CTRL_RESET[acc_pkg::BIT_TSEL:0];
      end else if (regWr && hit(regAddr, acc_pkg::OFF_CTRL)) begin
        // Done bit is not writable
        tsel_r  <= regWdata[acc_pkg::BIT_TSEL];
        aiDis_r <= regWdata[acc_pkg::BIT_AIDIS];
        chan_r  <= regWdata[acc_pkg::CHAN_MSB:0];
      end
    end
  end

  // Pins toward the analog multiplexer
  // Reserved codes stay in the field and read back as written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanSel        <= '0;
      analogInEnable <= 1'b0;
    end else if (clkEn) begin
      chanSel        <= chan_r;
      // Reserved codes leave the multiplexer open
      analogInEnable <= !aiDis_r && (chan_r <= acc_pkg::CHAN_LAST);
    end
  end

  // Conversion sequencer: busy, elapsed count, track phase
  // A start write restarts the count even mid-conversion
  // Low power beats a start, since control writes are ignored then
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      convBusy    <= 1'b0;
      convCnt_r   <= '0;
      sampleTrack <= 1'b0;
    end else if (clkEn) begin
      if (lpActive) begin
        // Abort; result is not updated
        convBusy    <= 1'b0;
        sampleTrack <= 1'b0;
      end else if (startPulse) begin
        // Fresh start, also over a running conversion
        convBusy    <= 1'b1;
        convCnt_r   <= '0;
        sampleTrack <= 1'b1;
      end else if (convEnd) begin
        convBusy    <= 1'b0;
      end else if (convBusy) begin
        convCnt_r   <= convCnt_r + 1'b1;
        // Hold the input once the capacitor has charged
        if (sarIf.clear) begin
          sampleTrack <= 1'b0;
        end
      end
    end
  end

  // Trial step timer, started at the sample point
  // Runs down past the last bit; steps after the finish are ignored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stepCnt_r <= '0;
    end else if (clkEn) begin
      if (sarIf.clear || sarIf.step) begin
        stepCnt_r <= stepLen;
      end else if (stepCnt_r != '0) begin
        stepCnt_r <= stepCnt_r - 1'b1;
      end
    end
  end

  // Result capture at the end of each conversion
  // Abort and restart leave the last good value standing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
    end else if (clkEn && convEnd) begin
      result_r <= sarIf.code;
    end
  end

  // Done flag: set at end wins over a clearing read
  // Losing the set would hide a fresh result from software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag_r <= 1'b0;
    end else if (clkEn) begin
      if (convEnd) begin
        doneFlag_r <= 1'b1;
      end else if (lpActive || startPulse) begin
        doneFlag_r <= 1'b0;
      end else if (resultRd) begin
        doneFlag_r <= 1'b0;
      end
    end
  end

  // Event status and mask next values
  // Status bits clear by writing ones; the mask is a plain copy
  always_comb begin
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    if (regWr && hit(regAddr, acc_pkg::OFF_IRQSTAT)) begin
      irqStat_nxt = irqStat_nxt & ~regWdata[acc_pkg::IRQ_W-1:0];
    end
    if (regWr && hit(regAddr, acc_pkg::OFF_IRQMASK)) begin
      irqMask_nxt = regWdata[acc_pkg::IRQ_W-1:0];
    end
    // Setting comes last so it wins over a clear
    if (convEnd) begin
      irqStat_nxt[acc_pkg::IRQ_DONE] = 1'b1;
    end
    if (abortEvt) begin
      irqStat_nxt[acc_pkg::IRQ_ABORT] = 1'b1;
    end
  end

  // Event registers and interrupt line
  // Built from next values, so irq moves with the status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= acc_pkg::IRQ_RESET;
      irqMask_r <= acc_pkg::IRQ_RESET;
      irq       <= 1'b0;
    end else if (clkEn) begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      irq       <= |(irqStat_nxt & irqMask_nxt);
    end
  end

  // Read data, valid only in the cycle after the strobe
  // Zero otherwise, so the bus can be ORed with other slaves
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (clkEn) begin
      regRdata <= '0;
      if (regRd) begin
        if (hit(regAddr, acc_pkg::OFF_CTRL)) begin
          regRdata <= ctrlView;
        end else if (hit(regAddr, acc_pkg::OFF_RESULT)) begin
          regRdata <= acc_pkg::DATA_W'(result_r);
        end else if (hit(regAddr, acc_pkg::OFF_IRQSTAT)) begin
          regRdata <= acc_pkg::DATA_W'(irqStat_r);
        end else if (hit(regAddr, acc_pkg::OFF_IRQMASK)) begin
          regRdata <= acc_pkg::DATA_W'(irqMask_r);
        end
      end
    end
  end

  // Checks; reset disables them all, and the clock enable stands in
  // every antecedent where a frozen cycle would change the outcome
  // One clock domain, so default clocking serves every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Register map and multiplexer
  a_ctrl_readback: assert property (
      clkEn && regRd && hit(regAddr, acc_pkg::OFF_CTRL) |=> regRdata == $past(ctrlView))
      else $error("control readback wrong");
  a_chan_route: assert property (
      clkEn && !aiDis_r && chan_r <= acc_pkg::CHAN_LAST |=>
      analogInEnable && chanSel == $past(chan_r)) else $error("channel not routed");
  a_chan_reserved: assert property (
      clkEn && chan_r > acc_pkg::CHAN_LAST |=> !analogInEnable)
      else $error("reserved code routed");
  a_input_off: assert property (
      clkEn && aiDis_r |=> !analogInEnable) else $error("disabled input routed");
  // Start, length and restart
  a_start_runs: assert property (
      clkEn && startPulse |=> convBusy && sampleTrack && convCnt_r == '0)
      else $error("start did not begin conversion");
  a_conv_length: assert property (
      clkEn && convEnd |-> convCnt_r == totalCyc - 1'b1 ##1 !convBusy && doneFlag_r)
      else $error("conversion length wrong");
  a_restart_count: assert property (
      clkEn && convBusy && convCnt_r != '0 && startPulse |=> convCnt_r == '0 && !doneFlag_r)
      else $error("restart not from beginning");
  // Sample point and trial code
  a_sample_point: assert property (
      $fell(sampleTrack) && $past(convBusy) && !$past(lpActive) |->
      $past(convCnt_r) == acc_pkg::SAMPLE_CYC - 1'b1) else $error("sample at wrong time");
  a_sar_clear: assert property (
      clkEn && sarIf.clear |=> dacCode == {1'b1, {(RES_W-1){1'b0}}})
      else $error("trial code not reset at sample");
  a_idle_hold: assert property (
      !convBusy |-> !sampleTrack) else $error("tracking while idle");
  // Done flag
  a_done_idle: assert property (
      doneFlag_r |-> !convBusy) else $error("done during conversion");
  a_done_nowrite: assert property (
      clkEn && !doneFlag_r && !convEnd |=> !doneFlag_r)
      else $error("done set without conversion end");
  a_done_wins: assert property (
      clkEn && convEnd && resultRd |=> doneFlag_r) else $error("end lost to result read");
  a_read_clears: assert property (
      clkEn && resultRd && !convEnd |=> !doneFlag_r) else $error("result read left done set");
  a_done_event: assert property (
      clkEn && convEnd |=> irqStat_r[acc_pkg::IRQ_DONE]) else $error("done event missing");
  // Low power
  a_lowpower_wipe: assert property (
      clkEn && lpActive |=> ctrlView == acc_pkg::CTRL_RESET)
      else $error("low power left control set");
  a_stop_abort: assert property (
      clkEn && stopMode && convBusy |=> !convBusy && $stable(result_r))
      else $error("stop did not abort");
  a_slow_abort: assert property (
      clkEn && slowMode |=> !convBusy && !sampleTrack) else $error("slow mode left busy");
  a_abort_flag: assert property (
      clkEn && abortEvt |=> irqStat_r[acc_pkg::IRQ_ABORT]) else $error("abort event missing");
  // Result register
  a_result_hold: assert property (
      !(clkEn && convEnd) |=> $stable(result_r))
      else $error("result changed without completion");
  a_result_read: assert property (
      clkEn && resultRd |=> regRdata == acc_pkg::DATA_W'($past(result_r)))
      else $error("result readback wrong");
  // Interrupt line and read bus
  a_irq_level: assert property (
      irq == |(irqStat_r & irqMask_r)) else $error("interrupt line wrong");
  a_rdata_idle: assert property (
      clkEn && !regRd |=> regRdata == '0) else $error("read data outside read cycle");

  // Main scenarios to see covered
  c_short_done: cover property (convEnd && !tsel_r);
  c_long_done: cover property (convEnd && tsel_r);
  c_restart: cover property (convBusy && startPulse);
  c_stop_abort: cover property (abortEvt && stopMode);
  c_read_clear: cover property (resultRd && doneFlag_r);
endmodule : acc_conv_ctrl
`default_nettype wire

// ---- bench/acc_analog_model.sv ----
// Behavioural model of the analog mux, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
  input  wire logic             core_clk,       // fc clock
  input  wire logic [11:0][7:0] levels,         // Input level of each channel
  input  wire logic [3:0]       chanSel,        // Selected channel
  input  wire logic             analogInEnable, // Mux connects the input
  input  wire logic             sampleTrack,    // Track high, hold low
  input  wire logic [7:0]       dacCode,        // Trial code from the ladder
  output var  logic             compIn          // High while held level reaches trial
);
  logic [7:0] heldLevel_r = 8'h5A; // Charge on the sample capacitor

  // Capacitor follows the routed channel while tracking, holds after
  always @(posedge core_clk) begin
    if (sampleTrack && analogInEnable && chanSel <= 4'hB) begin
      heldLevel_r <= levels[chanSel];
    end else if (sampleTrack) begin
      // Disconnected input drifts, never a steady value
      heldLevel_r <= ~heldLevel_r;
    end
  end

  // Comparator answers at once, with no synchroniser of its own
  assign compIn = (heldLevel_r >= dacCode);
endmodule : acc_analog_model
`default_nettype wire

// ---- bench/adc_conversion_control_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin nErrors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module adc_conversion_control_tb;
  logic             core_clk;       // fc clock
  logic             rst_n;          // Async reset, active low
  logic             clkEn;          // Clock enable
  logic [7:0]       regAddr;        // Register address
  logic [7:0]       regWdata;       // Write data
  logic             regWr;          // Write strobe
  logic             regRd;          // Read strobe
  logic [7:0]       regRdata;       // Read data
  logic             stopMode;       // Stop mode
  logic             slowMode;       // Slow mode
  logic             compIn;         // Comparator verdict
  logic [3:0]       chanSel;        // Mux channel
  logic             analogInEnable; // Mux enable
  logic             sampleTrack;    // Track high, hold low
  logic [7:0]       dacCode;        // Trial code
  logic             convBusy;       // Conversion running
  logic             irq;            // Interrupt
  logic [11:0][7:0] levels;         // Channel input levels
  logic [31:0]      rnd;            // Random state
  logic [7:0]       rd;             // Last read value
  logic             maskDone;       // Mask bit of the done event
  int               nErrors;        // Mismatches
  int               checked;        // Comparisons

  acc_conv_ctrl u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .stopMode(stopMode), .slowMode(slowMode), .compIn(compIn), .chanSel(chanSel),
    .analogInEnable(analogInEnable), .sampleTrack(sampleTrack), .dacCode(dacCode),
    .convBusy(convBusy), .irq(irq)
  );

  acc_analog_model u_analog (
    .core_clk(core_clk), .levels(levels), .chanSel(chanSel),
    .analogInEnable(analogInEnable), .sampleTrack(sampleTrack),
    .dacCode(dacCode), .compIn(compIn)
  );

  // Clock generator
  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask : wr

  // One-cycle register read, data taken in the following cycle
  task automatic rdReg(input logic [7:0] a);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 rd = regRdata;
  endtask : rdReg

  // One-cycle pulse of stop (or slow) mode
  task automatic lowPow(input logic stop);
    @(posedge core_clk);
    stopMode <= stop;
    slowMode <= !stop;
    @(posedge core_clk);
    stopMode <= 1'b0;
    slowMode <= 1'b0;
  endtask : lowPow

  // Conversion with timing and result checks; early restarts a running one
  task automatic conv(input logic tsel, input logic [3:0] ch, input int early);
    int         total;
    logic [7:0] e;
    total = tsel ? int'(acc_pkg::LONG_CYC) : int'(acc_pkg::SHORT_CYC);
    rnd = lfsr(rnd);
    levels[ch] = rnd[7:0];
    e = {2'b01, tsel, 1'b0, ch};
    if (early > 0) begin
      wr(acc_pkg::OFF_CTRL, e);
      repeat (early) @(posedge core_clk);
    end
    wr(acc_pkg::OFF_CTRL, e);
    repeat (int'(acc_pkg::SAMPLE_CYC) - 1) @(posedge core_clk);
    #1 `CHK("track", 1'b1, sampleTrack)
    @(posedge core_clk);
    #1 `CHK("hold", 1'b0, sampleTrack)
    `CHK("dacStart", 8'h80, dacCode)
    repeat (total - int'(acc_pkg::SAMPLE_CYC) - 1) @(posedge core_clk);
    #1 `CHK("busy", 1'b1, convBusy)
    @(posedge core_clk);
    #1 `CHK("ended", 1'b0, convBusy)
    `CHK("irq", maskDone, irq)
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("doneSet", {2'b10, tsel, 1'b0, ch}, rd)
    rdReg(acc_pkg::OFF_RESULT);
    `CHK("result", levels[ch], rd)
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("doneClr", {2'b00, tsel, 1'b0, ch}, rd)
    wr(acc_pkg::OFF_RESULT, ~levels[ch]);
    rdReg(acc_pkg::OFF_RESULT);
    `CHK("resultRo", levels[ch], rd)
    wr(acc_pkg::OFF_IRQSTAT, 8'h01);
    #1 `CHK("irqClr", 1'b0, irq)
  endtask : conv

  // Verdict and end of run
  task automatic stop_test;
    if (nErrors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge core_clk);
    nErrors++;
    stop_test();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    {regAddr, regWdata, regWr, regRd, stopMode, slowMode} = '0;
    levels = '0;
    rnd = 32'h64A9835F;
    maskDone = 1'b0;
    nErrors = 0;
    checked = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("ctrlReset", 8'h00, rd)
    rdReg(8'h3C);
    `CHK("unmapped", 8'h00, rd)
    // Frozen clock enable ignores a write
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(acc_pkg::OFF_CTRL, 8'h25);
    clkEn <= 1'b1;
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("frozen", 8'h00, rd)
    // Every channel code, random time and disable bits, done bit written high
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      wr(acc_pkg::OFF_CTRL, {2'b10, rnd[1:0], 4'(i)});
      rdReg(acc_pkg::OFF_CTRL);
      `CHK("ctrlRw", {2'b00, rnd[1:0], 4'(i)}, rd)
      `CHK("chanSel", 4'(i), chanSel)
      `CHK("inEnable", !rnd[0] && i <= 11, analogInEnable)
    end
    conv(1'b0, 4'h0, 0);
    wr(acc_pkg::OFF_IRQMASK, 8'h03);
    maskDone = 1'b1;
    conv(1'b0, 4'hB, 0);
    conv(1'b1, 4'h4, 0);
    conv(1'b0, 4'h7, 100);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      conv(rnd[9], 4'(rnd[7:0] % 8'd12), 0);
    end
    // Stop after completion keeps the result
    levels[3] = rnd[15:8];
    wr(acc_pkg::OFF_CTRL, 8'h43);
    repeat (200) @(posedge core_clk);
    lowPow(1'b1);
    rdReg(acc_pkg::OFF_RESULT);
    `CHK("kept", levels[3], rd)
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("ctrlStop", 8'h00, rd)
    // Stop in mid conversion aborts it
    wr(acc_pkg::OFF_IRQSTAT, 8'h03);
    wr(acc_pkg::OFF_CTRL, 8'h45);
    repeat (50) @(posedge core_clk);
    lowPow(1'b1);
    #1 `CHK("abort", 1'b0, convBusy)
    rdReg(acc_pkg::OFF_IRQSTAT);
    `CHK("abortFlag", 8'h02, rd)
    // Slow mode clears the control register as well
    wr(acc_pkg::OFF_CTRL, 8'h35);
    lowPow(1'b0);
    rdReg(acc_pkg::OFF_CTRL);
    `CHK("ctrlSlow", 8'h00, rd)
    stop_test();
  end
endmodule : adc_conversion_control_tb
`default_nettype wire
